// file: core/urcf_uart.sv
/*
  Full-duplex asynchronous serial port with active-low request-to-send and
  clear-to-send flow control, parity generation and checking, and an
  eight-word receive buffer. Holds the buffer module and the port top.
  Assumes one 250 MHz clock i_mclk, a synchronous active-low reset i_rstn,
  and pins that arrive from outside the clock domain.
*/
`default_nettype none

// receive buffer: width and depth shape the storage
module urcf_fifo #(
  parameter int unsigned W = 10,
  parameter int unsigned DEPTH = 8,
  parameter int unsigned CW = 4
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [W-1:0] i_in_data,
  // drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [W-1:0] o_out_data,
  // fill level
  output logic [CW-1:0] o_count
);
  logic [W-1:0] mem_q [DEPTH];
  logic [CW-2:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  // pointer and level update; full and empty come from the level only
  always_comb begin
    push = i_in_valid && o_in_ready;
    pop = o_out_valid && i_out_ready;
    wr_d = push ? wr_q + 1'h1 : wr_q;
    rd_d = pop ? rd_q + 1'h1 : rd_q;
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'h1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'h1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset; words are only read once written
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_q[wr_q] <= i_in_data;
    end
  end

  assign o_in_ready = (cnt_q != CW'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rd_q];
  assign o_count = cnt_q;

endmodule : urcf_fifo

module urcf_uart
  import urcf_pkg::*;
(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rstn,
  // line configuration, static while characters move
  input wire logic [URCF_DIV_W-1:0] i_baud_div,
  input wire logic i_parity_en,
  input wire logic i_parity_odd,
  input wire logic i_two_stop,
  // characters to send
  input wire logic i_tx_valid,
  output logic o_tx_ready,
  input wire logic [URCF_DATA_W-1:0] i_tx_data,
  // received characters
  output logic o_rx_valid,
  input wire logic i_rx_ready,
  output urcf_rx_char_t o_rx_char,
  output logic o_rx_overrun,
  // pins: transmit, receive, request-to-send, clear-to-send
  output logic o_shared_pin_twenty_one,
  output logic o_shared_pin_twenty_one_oe_n,
  input wire logic i_shared_pin_twenty_two,
  output logic o_shared_pin_twenty_two_pullup,
  output logic o_shared_pin_twenty_three,
  output logic o_shared_pin_twenty_three_oe_n,
  input wire logic i_shared_pin_twenty_four,
  output logic o_shared_pin_twenty_four_pulldown
);

  typedef enum logic [2:0] {
    URCF_S_IDLE,
    URCF_S_START,
    URCF_S_DATA,
    URCF_S_PAR,
    URCF_S_STOP
  } urcf_state_t;

  // parity bit for a character: even or odd sense
  function automatic logic urcf_parity(input logic [URCF_DATA_W-1:0] d, input logic odd);
    urcf_parity = (^d) ^ odd;
  endfunction : urcf_parity

  // two-flop synchronisers for the receive and clear-to-send pins
  logic [1:0] rx_sync_q, rx_sync_d, cts_sync_q, cts_sync_d;
  logic rxd, cts_on;

  always_comb begin
    rx_sync_d = {rx_sync_q[0], i_shared_pin_twenty_two};
    cts_sync_d = {cts_sync_q[0], i_shared_pin_twenty_four};
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      rx_sync_q <= {2{URCF_LINE_IDLE}};
      cts_sync_q <= {2{URCF_HS_DEASSERTED}};
    end else begin
      rx_sync_q <= rx_sync_d;
      cts_sync_q <= cts_sync_d;
    end
  end

  assign rxd = rx_sync_q[1];
  assign cts_on = (cts_sync_q[1] == URCF_HS_ASSERTED);

  // transmit path
  urcf_state_t tx_st_q, tx_st_d;
  logic [URCF_DIV_W-1:0] tx_cnt_q, tx_cnt_d;
  logic [URCF_BIT_W-1:0] tx_bit_q, tx_bit_d;
  logic [URCF_DATA_W-1:0] tx_sh_q, tx_sh_d;
  logic tx_par_q, tx_par_d;
  logic tx_line_q, tx_line_d;
  logic tx_tick;

  // a held-off character waits in idle; one already on the wire completes
  always_comb begin
    tx_st_d = tx_st_q;
    tx_cnt_d = tx_cnt_q;
    tx_bit_d = tx_bit_q;
    tx_sh_d = tx_sh_q;
    tx_par_d = tx_par_q;
    tx_line_d = tx_line_q;
    tx_tick = (tx_cnt_q == i_baud_div - 1'h1);
    o_tx_ready = (tx_st_q == URCF_S_IDLE) && cts_on;
    if (tx_st_q != URCF_S_IDLE) begin
      tx_cnt_d = tx_tick ? '0 : tx_cnt_q + 1'h1;
    end
    case (tx_st_q)
      URCF_S_IDLE: begin
        tx_line_d = URCF_LINE_IDLE;
        if (i_tx_valid && o_tx_ready) begin
          tx_sh_d = i_tx_data;
          tx_par_d = urcf_parity(i_tx_data, i_parity_odd);
          tx_cnt_d = '0;
          tx_line_d = URCF_LINE_START;
          tx_st_d = URCF_S_START;
        end
      end
      URCF_S_START: begin
        if (tx_tick) begin
          tx_bit_d = '0;
          tx_line_d = tx_sh_q[0];
          tx_st_d = URCF_S_DATA;
        end
      end
      URCF_S_DATA: begin
        if (tx_tick) begin
          tx_sh_d = tx_sh_q >> 1;
          tx_bit_d = tx_bit_q + 1'h1;
          tx_line_d = tx_sh_q[1];
          if (tx_bit_q == URCF_LAST_BIT) begin
            tx_bit_d = '0;
            tx_line_d = i_parity_en ? tx_par_q : URCF_LINE_IDLE;
            tx_st_d = i_parity_en ? URCF_S_PAR : URCF_S_STOP;
          end
        end
      end
      URCF_S_PAR: begin
        if (tx_tick) begin
          tx_line_d = URCF_LINE_IDLE;
          tx_st_d = URCF_S_STOP;
        end
      end
      URCF_S_STOP: begin
        if (tx_tick) begin
          if (i_two_stop && tx_bit_q == '0) begin
            tx_bit_d = 3'h1;
          end else begin
            tx_bit_d = '0;
            tx_st_d = URCF_S_IDLE;
          end
        end
      end
      default: begin
        tx_line_d = URCF_LINE_IDLE;
        tx_st_d = URCF_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      tx_st_q <= URCF_S_IDLE;
      tx_cnt_q <= '0;
      tx_bit_q <= '0;
      tx_sh_q <= '0;
      tx_par_q <= 1'h0;
      tx_line_q <= URCF_LINE_IDLE;
    end else begin
      tx_st_q <= tx_st_d;
      tx_cnt_q <= tx_cnt_d;
      tx_bit_q <= tx_bit_d;
      tx_sh_q <= tx_sh_d;
      tx_par_q <= tx_par_d;
      tx_line_q <= tx_line_d;
    end
  end

  // receive path, independent of the transmit path
  urcf_state_t rx_st_q, rx_st_d;
  logic [URCF_DIV_W-1:0] rx_cnt_q, rx_cnt_d;
  logic [URCF_BIT_W-1:0] rx_bit_q, rx_bit_d;
  logic [URCF_DATA_W-1:0] rx_sh_q, rx_sh_d;
  logic rx_perr_q, rx_perr_d;
  logic rx_push_q, rx_push_d;
  logic rx_ferr_q, rx_ferr_d;
  logic ovr_q, ovr_d;
  logic rx_tick, rx_mid;
  logic fifo_in_ready;
  logic [URCF_CNT_W-1:0] fifo_count;
  urcf_rx_char_t rx_word;

  // sampling mid-bit: start is rechecked half a bit in to reject glitches
  always_comb begin
    rx_st_d = rx_st_q;
    rx_cnt_d = rx_cnt_q + 1'h1;
    rx_bit_d = rx_bit_q;
    rx_sh_d = rx_sh_q;
    rx_perr_d = rx_perr_q;
    rx_ferr_d = rx_ferr_q;
    rx_push_d = 1'h0;
    rx_tick = (rx_cnt_q == i_baud_div - 1'h1);
    rx_mid = (rx_cnt_q == (i_baud_div >> 1));
    if (rx_tick) begin
      rx_cnt_d = '0;
    end
    case (rx_st_q)
      URCF_S_IDLE: begin
        rx_cnt_d = '0;
        if (rxd == URCF_LINE_START) begin
          rx_st_d = URCF_S_START;
        end
      end
      URCF_S_START: begin
        if (rx_mid) begin
          rx_cnt_d = '0;
          rx_bit_d = '0;
          rx_perr_d = 1'h0;
          rx_st_d = (rxd == URCF_LINE_START) ? URCF_S_DATA : URCF_S_IDLE;
        end
      end
      URCF_S_DATA: begin
        if (rx_tick) begin
          rx_sh_d = {rxd, rx_sh_q[URCF_DATA_W-1:1]};
          rx_bit_d = rx_bit_q + 1'h1;
          if (rx_bit_q == URCF_LAST_BIT) begin
            rx_st_d = i_parity_en ? URCF_S_PAR : URCF_S_STOP;
          end
        end
      end
      URCF_S_PAR: begin
        if (rx_tick) begin
          rx_perr_d = (rxd != urcf_parity(rx_sh_q, i_parity_odd));
          rx_st_d = URCF_S_STOP;
        end
      end
      URCF_S_STOP: begin
        // only the first stop bit is checked, so a second one is tolerated
        if (rx_tick) begin
          rx_ferr_d = (rxd != URCF_LINE_IDLE);
          rx_push_d = 1'h1;
          rx_st_d = URCF_S_IDLE;
        end
      end
      default: begin
        rx_st_d = URCF_S_IDLE;
      end
    endcase
    // overrun pulses when a finished character finds the buffer full
    ovr_d = rx_push_q && !fifo_in_ready;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      rx_st_q <= URCF_S_IDLE;
      rx_cnt_q <= '0;
      rx_bit_q <= '0;
      rx_sh_q <= '0;
      rx_perr_q <= 1'h0;
      rx_ferr_q <= 1'h0;
      rx_push_q <= 1'h0;
      ovr_q <= 1'h0;
    end else begin
      rx_st_q <= rx_st_d;
      rx_cnt_q <= rx_cnt_d;
      rx_bit_q <= rx_bit_d;
      rx_sh_q <= rx_sh_d;
      rx_perr_q <= rx_perr_d;
      rx_ferr_q <= rx_ferr_d;
      rx_push_q <= rx_push_d;
      ovr_q <= ovr_d;
    end
  end

  always_comb begin
    rx_word.data = rx_sh_q;
    rx_word.parity_err = rx_perr_q;
    rx_word.frame_err = rx_ferr_q;
  end

  // receive buffer; downloads pass through here like any other data
  urcf_fifo #(
    .W(URCF_RX_W),
    .DEPTH(URCF_FIFO_DEPTH),
    .CW(URCF_CNT_W)
  ) u_rx_fifo (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_in_valid(rx_push_q),
    .o_in_ready(fifo_in_ready),
    .i_in_data(rx_word),
    .o_out_valid(o_rx_valid),
    .i_out_ready(i_rx_ready),
    .o_out_data(o_rx_char),
    .o_count(fifo_count)
  );

  // request-to-send: drop it with room to spare for a character in flight
  logic rts_q, rts_d;

  always_comb begin
    rts_d = URCF_HS_ASSERTED;
    if (4'(URCF_FIFO_DEPTH) - fifo_count < URCF_RTS_FREE_MIN) begin
      rts_d = URCF_HS_DEASSERTED;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      rts_q <= URCF_HS_ASSERTED;
    end else begin
      rts_q <= rts_d;
    end
  end

  // pin drive and pad configuration, fixed after reset
  assign o_shared_pin_twenty_one = tx_line_q;
  assign o_shared_pin_twenty_one_oe_n = 1'h0;
  assign o_shared_pin_twenty_two_pullup = 1'h1;
  assign o_shared_pin_twenty_three = rts_q;
  assign o_shared_pin_twenty_three_oe_n = 1'h0;
  assign o_shared_pin_twenty_four_pulldown = 1'h1;
  assign o_rx_overrun = ovr_q;

endmodule : urcf_uart

`default_nettype wire

// file: inc/urcf_pkg.sv
/*
  Shared constants and types for the serial port with request-to-send and
  clear-to-send flow control: character width, receive buffer depth, the
  flow control threshold, line reset levels and the received-character carrier.
  Assumes the includer compiles it before the design file.
*/
`default_nettype none

package urcf_pkg;

  // character layout
  localparam int unsigned URCF_DATA_W = 8;
  localparam int unsigned URCF_BIT_W = 3;
  localparam logic [2:0] URCF_LAST_BIT = 3'h7;

  // receive buffer
  localparam int unsigned URCF_FIFO_DEPTH = 8;
  localparam int unsigned URCF_CNT_W = 4;
  // free slots below this make the port hold off the host
  localparam logic [3:0] URCF_RTS_FREE_MIN = 4'h2;

  // bit timing: divisor in clock cycles per bit
  localparam int unsigned URCF_DIV_W = 16;
  localparam logic [15:0] URCF_DIV_MIN = 16'h0002;

  // line levels; handshake lines are active low
  localparam logic URCF_LINE_IDLE = 1'h1;
  localparam logic URCF_LINE_START = 1'h0;
  localparam logic URCF_HS_ASSERTED = 1'h0;
  localparam logic URCF_HS_DEASSERTED = 1'h1;

  // one received character with its error flags
  typedef struct packed {
    logic [URCF_DATA_W-1:0] data;
    logic parity_err;
    logic frame_err;
  } urcf_rx_char_t;

  localparam int unsigned URCF_RX_W = $bits(urcf_rx_char_t);

endpackage : urcf_pkg

`default_nettype wire

// file: sim/urcf_uart_props.sv
/* pin and handshake checks for the serial port
   assumes the bind below; sees only the top ports */
`default_nettype none
module urcf_uart_props
  import urcf_pkg::*;
(
  // clock, reset, user side
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic i_tx_valid,
  input wire logic o_tx_ready,
  input wire logic o_rx_valid,
  input wire logic i_rx_ready,
  input wire urcf_rx_char_t o_rx_char,
  input wire logic o_rx_overrun,
  // pads
  input wire logic o_shared_pin_twenty_one,
  input wire logic o_shared_pin_twenty_one_oe_n,
  input wire logic o_shared_pin_twenty_two_pullup,
  input wire logic o_shared_pin_twenty_three,
  input wire logic o_shared_pin_twenty_three_oe_n,
  input wire logic i_shared_pin_twenty_four,
  input wire logic o_shared_pin_twenty_four_pulldown
);
  timeunit 1ns;
  timeprecision 1ps;
  // single clock domain
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);
  a_pads_set: assert property (
    !o_shared_pin_twenty_one_oe_n && !o_shared_pin_twenty_three_oe_n
    && o_shared_pin_twenty_two_pullup && o_shared_pin_twenty_four_pulldown)
    else $error("pad setup wrong");
  a_reset_levels: assert property (
    !$past(i_rstn) |-> o_shared_pin_twenty_one && !o_shared_pin_twenty_three)
    else $error("bad line level after reset");
  a_ready_cts: assert property (
    o_tx_ready |-> $past(i_shared_pin_twenty_four, 2) == URCF_HS_ASSERTED)
    else $error("ready without clear to send");
  a_take_busy: assert property (
    i_tx_valid && o_tx_ready |=> !o_tx_ready)
    else $error("ready after take");
  a_start_low: assert property (
    i_tx_valid && o_tx_ready |=> (o_shared_pin_twenty_one == URCF_LINE_START) [*2])
    else $error("start bit short");
  a_idle_high: assert property (
    o_tx_ready |-> o_shared_pin_twenty_one == URCF_LINE_IDLE)
    else $error("line low while idle");
  a_overrun_rts: assert property (
    o_rx_overrun |-> o_shared_pin_twenty_three == URCF_HS_DEASSERTED)
    else $error("overrun while asking");
  a_head_held: assert property (
    o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_char))
    else $error("head word changed");
endmodule : urcf_uart_props

bind urcf_uart urcf_uart_props u_props (.*);
`default_nettype wire

// file: sim/urcf_host.sv
/* host side model: serial port with active-low handshakes
   assumes the bench sets bit time and parity to match the port */
`default_nettype none
module urcf_host (
  // clock and line settings
  input wire logic i_clk,
  input wire logic [15:0] i_div,
  input wire logic i_pen,
  input wire logic i_podd,
  // serial lines, handshakes active low
  output logic o_txd,
  output logic o_cts_n,
  input wire logic i_rts_n,
  input wire logic i_rxd
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] rq[$];
  logic [9:0] w;
  // idle high; own cts line, never looped to rts
  initial begin
    o_txd = 1'h1;
    o_cts_n = 1'h0;
  end
  // one bit for a full bit time, changed just after an edge
  task automatic bit_out(input logic b);
    o_txd = b;
    repeat (i_div) @(posedge i_clk);
    #1;
  endtask : bit_out
  // waits for the port to ask, unless told to push on regardless
  task automatic send(input logic [7:0] d, input logic bad, input logic ign, output logic ok);
    for (int n = 0; n < 300 && i_rts_n !== 1'h0 && !ign; n++) @(posedge i_clk) #1;
    ok = ign || i_rts_n === 1'h0;
    if (!ok) return;
    bit_out(1'h0);
    for (int i = 0; i < 8; i++) bit_out(d[i]);
    if (i_pen) bit_out(^d ^ i_podd ^ bad);
    bit_out(1'h1);
  endtask : send
  // mid-bit sampling; keeps data with a flag for a good stop bit and, with parity on, good parity
  always begin
    @(negedge i_rxd);
    repeat (i_div / 2) @(posedge i_clk);
    w = 10'h3FF;
    for (int i = 0; i < (i_pen ? 10 : 9); i++) begin
      repeat (i_div) @(posedge i_clk);
      w[i] = i_rxd;
    end
    rq.push_back({(i_pen ? w[9] && (w[8] == (^w[7:0] ^ i_podd)) : w[8]), w[7:0]});
  end
endmodule : urcf_host
`default_nettype wire

// file: sim/urcf_uart_test.sv
/* self-checking bench for the serial port, host model on the pins
   assumes the host model and the bound checker are compiled */
`default_nettype none
module urcf_uart_test
  import urcf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rstn = 1'h0, pen = 1'h0, podd = 1'h0, two = 1'h0;
  logic txv = 1'h0, rxr = 1'h0, ovs = 1'h0, went;
  logic [7:0] txd = 8'h00;
  logic [7:0] fe;
  logic [15:0] div = 16'h0004;
  logic [31:0] seed = 32'h9EC4;
  wire logic txl, rxl, rts, cts, txr, rxv, ovr, oe1, oe3, pu, pd;
  urcf_rx_char_t rxc;
  int failures = 0, num_checks = 0;
  logic [9:0] expq[$];
  logic [7:0] txq[$];
  // 250 MHz; overrun is a one-cycle pulse, so latch it
  always #2 clk = ~clk;
  always @(posedge clk) if (ovr === 1'h1) ovs <= 1'h1;
  urcf_uart dut (.i_mclk(clk), .i_rstn(rstn), .i_baud_div(div), .i_parity_en(pen),
    .i_parity_odd(podd), .i_two_stop(two), .i_tx_valid(txv), .o_tx_ready(txr),
    .i_tx_data(txd), .o_rx_valid(rxv), .i_rx_ready(rxr), .o_rx_char(rxc),
    .o_rx_overrun(ovr), .o_shared_pin_twenty_one(txl),
    .o_shared_pin_twenty_one_oe_n(oe1), .i_shared_pin_twenty_two(rxl),
    .o_shared_pin_twenty_two_pullup(pu), .o_shared_pin_twenty_three(rts),
    .o_shared_pin_twenty_three_oe_n(oe3), .i_shared_pin_twenty_four(cts),
    .o_shared_pin_twenty_four_pulldown(pd));
  urcf_host host (.i_clk(clk), .i_div(div), .i_pen(pen), .i_podd(podd),
    .o_txd(rxl), .o_cts_n(cts), .i_rts_n(rts), .i_rxd(txl));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string s);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t %s: got %h exp %h", $time, s, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // a wait that used its bound ends the run
  task automatic tmo(input int n);
    if (n > 8999) begin
      chk(16'h0, 16'h1, "timeout");
      summarize();
    end
  endtask : tmo
  function automatic logic [7:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  // valid held until the edge that takes it, then one idle cycle
  task automatic put(input logic [7:0] d);
    int n = 0;
    txv = 1'h1;
    txd = d;
    do begin
      @(posedge clk);
      n++;
    end while (txr !== 1'h1 && n < 9000);
    #1 txv = 1'h0;
    tmo(n);
    txq.push_back(d);
    @(posedge clk) #1;
  endtask : put
  // a full buffer drops the new word
  task automatic hsend(input logic [7:0] d, input logic bad, input logic ign);
    host.send(d, bad, ign, went);
    if (went && expq.size() < URCF_FIFO_DEPTH) expq.push_back({d, pen & bad, 1'h0});
  endtask : hsend
  task automatic pop_all;
    int n;
    while (expq.size() > 0) begin
      for (n = 0; rxv !== 1'h1 && n < 9000; n++) @(posedge clk) #1;
      tmo(n);
      chk(rxc, expq.pop_front(), "rx word");
      rxr = 1'h1;
      @(posedge clk) #1 rxr = 1'h0;
      @(posedge clk) #1;
    end
  endtask : pop_all
  task automatic cmp_tx;
    int n;
    while (txq.size() > 0) begin
      for (n = 0; host.rq.size() == 0 && n < 9000; n++) @(posedge clk) #1;
      tmo(n);
      chk({1'h1, txq.pop_front()}, host.rq.pop_front(), "tx word");
    end
  endtask : cmp_tx
  // reset, then framing, handshake and fill scenarios
  initial begin
    repeat (12) @(posedge clk);
    #1 rstn = 1'h1;
    chk({txl, rts, oe1, oe3, pu, pd}, 16'h23, "pads");
    for (int k = 0; k < 4; k++) begin
      pen = (k > 0);
      podd = (k == 2);
      two = (k == 3);
      div = 16'(4 + k);
      fork
        begin
          put(rnd());
          put(rnd());
        end
        begin
          hsend(rnd(), 1'h0, 1'h0);
          hsend(rnd(), pen, 1'h0);
        end
      join
      pop_all();
      cmp_tx();
      $display("frame test %0d done", k);
    end
    host.o_cts_n = 1'h1;
    repeat (4) @(posedge clk);
    #1 fork
      put(rnd());
      begin
        repeat (20) @(posedge clk);
        #1 chk({txl, txr}, 16'h2, "cts hold");
        host.o_cts_n = 1'h0;
      end
    join
    cmp_tx();
    $display("handshake test done");
    div = 16'h0010;
    for (int i = 0; i < 10; i++) begin
      hsend(rnd(), 1'h0, 1'(i > 7));
      if (i == 7) chk(went, 16'h0, "host stall");
    end
    chk({rts, ovs}, 16'h3, "full");
    pop_all();
    chk(rts, 16'h0, "rts free");
    $display("fill test done");
    // stop bit held low flags a frame error; the low tail is no new start
    fe = rnd();
    host.bit_out(1'h0);
    for (int i = 0; i < 8; i++) host.bit_out(fe[i]);
    host.bit_out(^fe ^ podd);
    host.bit_out(1'h0);
    host.bit_out(1'h1);
    expq.push_back({fe, 2'h1});
    pop_all();
    chk(rxv, 16'h0, "ghost word");
    $display("frame error test done");
    summarize();
  end
endmodule : urcf_uart_test
`default_nettype wire
